// ==== hw/pviu_pkg.sv ====
package pviu_pkg;

   // Clocking of the instruction cycle
   localparam int CLK_PERIOD_NS    = 8;
   localparam int INSTR_CYCLE_NS   = 32;
   localparam int INSTR_DIV_CYCLES = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Sizes
   localparam int NUM_SRC = 11;
   localparam int NUM_GRP = 7;
   localparam int NUM_PIN = 6;
   localparam int PC_W    = 14;

   // Source numbering: pin 0, pin 1, timer A, timer B, pin 2, timer C, pin 3,
   // timer D, pin 4, A/D, serial
   localparam int SRC_PIN0 = 0;
   localparam int SRC_PIN1 = 1;
   localparam int SRC_TA   = 2;
   localparam int SRC_TB   = 3;
   localparam int SRC_PIN2 = 4;
   localparam int SRC_TC   = 5;
   localparam int SRC_PIN3 = 6;
   localparam int SRC_TD   = 7;
   localparam int SRC_PIN4 = 8;
   localparam int SRC_AD   = 9;
   localparam int SRC_SER  = 10;
   localparam int PIN_STOP_CANCEL_INPUT = 5;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_CTL0   = 6'h00;
   localparam logic [5:0] IDX_CTL1   = 6'h01;
   localparam logic [5:0] IDX_CTL2   = 6'h02;
   localparam logic [5:0] IDX_CTL3   = 6'h03;
   localparam logic [5:0] IDX_CTL22  = 6'h22;
   localparam logic [5:0] IDX_CTL23  = 6'h23;
   localparam logic [5:0] IDX_EDGE_SELECT_REG_ONE   = 6'h26;
   localparam logic [5:0] IDX_EDGE_SELECT_REG_TWO   = 6'h27;
   localparam logic [5:0] IDX_STATUS = 6'h30;

   // Per source: register index, pair (flag at bit 2*pair, mask at 2*pair+1), group
   localparam logic [5:0] SRC_REG [NUM_SRC] = '{6'h00, 6'h01, 6'h01, 6'h02, 6'h22, 6'h02,
                                                6'h22, 6'h03, 6'h23, 6'h03, 6'h23};
   localparam int SRC_PAIR [NUM_SRC] = '{1, 0, 1, 0, 0, 1, 1, 0, 0, 1, 1};
   localparam int SRC_GRP  [NUM_SRC] = '{0, 1, 2, 3, 3, 4, 4, 5, 5, 6, 6};

   // Field positions of a register write
   localparam int IE_BIT        = 0;
   localparam int BITOP_FLAG    = 8;
   localparam int BITOP_SEL_LSB = 4;
   localparam int BITOP_VAL     = 0;

   // Reset values
   localparam logic               IE_RST  = 1'b0;
   localparam logic [NUM_SRC-1:0] IF_RST  = 11'h000;
   localparam logic [NUM_SRC-1:0] IM_RST  = 11'h7FF;
   localparam logic [3:0]         ESR_RST = 4'h0;
   localparam logic [NUM_PIN-1:0] PIN_IDLE = 6'h1F;

   // Edge modes
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_RISE = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // Vectors
   localparam logic [PC_W-1:0] VEC_RESET = 14'h0000;
   localparam int              VEC_STEP  = 2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ACK1 = 2'h1,
      ST_ACK2 = 2'h3,
      ST_ACK3 = 2'h2
   } pviu_state_t;

endpackage

// ==== hw/pviu_edge_if.sv ====
interface pviu_edge_if;
   logic [11:0] edge_mode;
   logic [5:0]  pin_event;
   modport ctrl (output edge_mode, input pin_event);
   modport det  (input edge_mode, output pin_event);
endinterface

// ==== hw/pviu_edge_det.sv ====
module pviu_edge_det (
   // Clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       reset,
   // Raw pins
   input  wire logic [pviu_pkg::NUM_PIN-1:0] pin_raw,
   // Edge modes in, events out
   pviu_edge_if.det                        eif
);
   import pviu_pkg::*;

   logic [NUM_PIN-1:0] s1_q;
   logic [NUM_PIN-1:0] s2_q;
   logic [NUM_PIN-1:0] s3_q;
   logic [NUM_PIN-1:0] lvl_q;
   logic [NUM_PIN-1:0] ev_q;

   assign eif.pin_event = ev_q;

   for (genvar p = 0; p < NUM_PIN; p++) begin : g_pin
      logic chg;
      assign chg = (s2_q[p] == s3_q[p]) && (s3_q[p] != lvl_q[p]);

      always_ff @(posedge core_clk or posedge reset) begin
         if (reset) begin
            s1_q[p] <= PIN_IDLE[p];
            s2_q[p] <= PIN_IDLE[p];
            s3_q[p] <= PIN_IDLE[p];
         end else begin
            s1_q[p] <= pin_raw[p];
            s2_q[p] <= s1_q[p];
            s3_q[p] <= s2_q[p];
         end
      end

      // A change counts once the second and third stages agree
      always_ff @(posedge core_clk or posedge reset) begin
         if (reset) begin
            lvl_q[p] <= PIN_IDLE[p];
            ev_q[p]  <= 1'b0;
         end else begin
            if (chg) begin
               lvl_q[p] <= s3_q[p];
            end
            ev_q[p] <= chg && ((s3_q[p] && eif.edge_mode[2*p+1]) ||
                               (!s3_q[p] && eif.edge_mode[2*p]));
         end
      end
   end

endmodule

// ==== hw/pviu_irq_unit.sv ====
// Function
// - Eleven sources: five pins, four timers, serial, A/D
// - Each source has flag, mask, vector; global enable
// - Four vectors are shared by two sources
// - Control bits at 000-003, 022-023, bit-addressable
// - Software can never set a request flag
// - Reset clears enable and flags, sets masks
// - Pending is flag and not mask; acceptance needs enable
// - Fixed priority picks vector 0002 to 000E
// - Acknowledge: finish instruction, then clear enable
// - Push carry, status, pointer; branch third cycle
// - Reset and stop cancel go to 0000
// - Pins 0,1 falling edge; pins 2-4 selectable
// - Enable cleared on entry, set by return
module pviu_irq_unit (
   // Clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        reset,
   // APB slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // External pins, request pins active low
   input  wire logic                        ext_irq_pin_zero_n,
   input  wire logic                        ext_irq_pin_one_n,
   input  wire logic                        ext_irq_pin_two_n,
   input  wire logic                        ext_irq_pin_three_n,
   input  wire logic                        ext_irq_pin_four_n,
   input  wire logic                        stop_cancel_input,
   // On-chip request pulses
   input  wire logic                        timer_a_ovf,
   input  wire logic                        timer_b_ovf,
   input  wire logic                        timer_c_ovf,
   input  wire logic                        timer_d_ovf,
   input  wire logic                        serial_req,
   input  wire logic                        adc_req,
   // Core sequencer
   input  wire logic                        stop_mode,
   input  wire logic                        return_from_irq_instruction_exec,
   output logic                             instr_cycle_en,
   output logic                             ack_busy,
   output logic                             push_flags,
   output logic                             push_pc,
   output logic                             branch_en,
   output logic      [pviu_pkg::PC_W-1:0]   branch_vector,
   output logic                             restore_flags,
   output logic                             stop_wake,
   output logic                             irq_pending
);
   import pviu_pkg::*;

   pviu_edge_if eif ();

   logic               cyc_en_q;
   logic [7:0]         div_q;
   logic               pready_q;
   logic [31:0]        prdata_q;
   logic               pslverr_q;
   logic               ie_q;
   logic [NUM_SRC-1:0] if_q;
   logic [NUM_SRC-1:0] im_q;
   logic [3:0]         edge_select_reg_one_q;
   logic [3:0]         edge_select_reg_two_q;
   pviu_state_t        st_q;
   pviu_state_t        st_d;
   logic [PC_W-1:0]    vec_q;
   logic               ack_busy_q;
   logic               push_flags_q;
   logic               push_pc_q;
   logic               branch_en_q;
   logic               restore_q;
   logic               wake_q;
   logic               pend_any_q;

   logic [5:0]         idx;
   logic               setup;
   logic               wr_en;
   logic               hit;
   logic [3:0]         rd_nib;
   logic [3:0]         wval;
   logic [NUM_SRC-1:0] wr_hit;
   logic [NUM_SRC-1:0] clr_now;
   logic [NUM_SRC-1:0] src_set;
   logic [NUM_SRC-1:0] pend;
   logic [NUM_GRP-1:0] grp_pend;
   logic [PC_W-1:0]    enc_vec;
   logic               accept;
   logic               wake;

   pviu_edge_det u_edge (
      .core_clk (core_clk),
      .reset    (reset),
      .pin_raw  ({stop_cancel_input, ext_irq_pin_four_n, ext_irq_pin_three_n,
                  ext_irq_pin_two_n, ext_irq_pin_one_n, ext_irq_pin_zero_n}),
      .eif      (eif.det)
   );

   // Pins 0 and 1 fixed falling, pins 2-4 from edge selects, stop cancel rising
   assign eif.edge_mode = {EDGE_RISE, edge_select_reg_two_q[1:0], edge_select_reg_one_q[3:2], edge_select_reg_one_q[1:0],
                           EDGE_FALL, EDGE_FALL};

   assign prdata         = prdata_q;
   assign pready         = pready_q;
   assign pslverr        = pslverr_q;
   assign instr_cycle_en = cyc_en_q;
   assign ack_busy       = ack_busy_q;
   assign push_flags     = push_flags_q;
   assign push_pc        = push_pc_q;
   assign branch_en      = branch_en_q;
   assign branch_vector  = vec_q;
   assign restore_flags  = restore_q;
   assign stop_wake      = wake_q;
   assign irq_pending    = pend_any_q;

   // Instruction-cycle enable divider
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         div_q    <= 8'h00;
         cyc_en_q <= 1'b0;
      end else if (div_q == 8'(INSTR_DIV_CYCLES - 1)) begin
         div_q    <= 8'h00;
         cyc_en_q <= 1'b1;
      end else begin
         div_q    <= div_q + 8'h01;
         cyc_en_q <= 1'b0;
      end
   end

   // APB decode
   assign idx   = paddr[7:2];
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready_q && pwrite && hit;

   always_comb begin
      rd_nib = 4'h0;
      hit    = (idx == IDX_EDGE_SELECT_REG_ONE) || (idx == IDX_EDGE_SELECT_REG_TWO) || (idx == IDX_STATUS);
      if (idx == IDX_CTL0) begin
         rd_nib[IE_BIT] = ie_q;
         hit            = 1'b1;
      end
      for (int i = 0; i < NUM_SRC; i++) begin
         if (idx == SRC_REG[i]) begin
            rd_nib[2*SRC_PAIR[i]]   = if_q[i];
            rd_nib[2*SRC_PAIR[i]+1] = im_q[i];
            hit                     = 1'b1;
         end
      end
      if (idx == IDX_STATUS) begin
         rd_nib = {pend_any_q, ack_busy_q, st_q};
      end
   end

   // Full nibble write, or single-bit set/clear of the selected bit
   always_comb begin
      wval = pwdata[3:0];
      if (pwdata[BITOP_FLAG]) begin
         wval = rd_nib;
         wval[pwdata[BITOP_SEL_LSB +: 2]] = pwdata[BITOP_VAL];
      end
   end

   // One wait-free access: pready rises in the access phase
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup && !hit;
         if (setup) begin
            prdata_q <= {28'h000_0000, pwrite ? 4'h0 : rd_nib};
         end
      end
   end

   // Edge selects, write-only
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         edge_select_reg_one_q <= ESR_RST;
         edge_select_reg_two_q <= ESR_RST;
      end else if (wr_en) begin
         if (idx == IDX_EDGE_SELECT_REG_ONE) begin
            edge_select_reg_one_q <= wval;
         end
         if (idx == IDX_EDGE_SELECT_REG_TWO) begin
            edge_select_reg_two_q <= wval;
         end
      end
   end

   assign src_set = {serial_req, adc_req, eif.pin_event[4], timer_d_ovf,
                     eif.pin_event[3], timer_c_ovf, eif.pin_event[2], timer_b_ovf,
                     timer_a_ovf, eif.pin_event[1], eif.pin_event[0]};

   // Flag and mask per source
   for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
      assign wr_hit[i]  = wr_en && (idx == SRC_REG[i]);
      assign clr_now[i] = wr_hit[i] && !wval[2*SRC_PAIR[i]];

      // Hardware set wins over a software clear; a write of 1 only keeps the flag
      always_ff @(posedge core_clk or posedge reset) begin
         if (reset) begin
            if_q[i] <= IF_RST[i];
         end else if (src_set[i]) begin
            if_q[i] <= 1'b1;
         end else if (clr_now[i]) begin
            if_q[i] <= 1'b0;
         end
      end

      always_ff @(posedge core_clk or posedge reset) begin
         if (reset) begin
            im_q[i] <= IM_RST[i];
         end else if (wr_hit[i]) begin
            im_q[i] <= wval[2*SRC_PAIR[i]+1];
         end
      end
   end

   assign pend = if_q & ~im_q & ~clr_now;

   // Shared vectors merge two sources into one group
   always_comb begin
      grp_pend = '0;
      for (int i = 0; i < NUM_SRC; i++) begin
         grp_pend[SRC_GRP[i]] = grp_pend[SRC_GRP[i]] | pend[i];
      end
   end

   // Lowest group number wins
   always_comb begin
      enc_vec = VEC_RESET;
      for (int g = NUM_GRP - 1; g >= 0; g--) begin
         if (grp_pend[g]) begin
            enc_vec = PC_W'((g + 1) * VEC_STEP);
         end
      end
   end

   assign accept = ie_q && (|grp_pend) && !stop_mode;
   assign wake   = stop_mode && eif.pin_event[PIN_STOP_CANCEL_INPUT];

   always_comb begin
      st_d = st_q;
      if (cyc_en_q) begin
         case (st_q)
            ST_IDLE: begin
               if (accept) begin
                  st_d = ST_ACK1;
               end
            end
            ST_ACK1: st_d = ST_ACK2;
            ST_ACK2: st_d = ST_ACK3;
            ST_ACK3: st_d = ST_IDLE;
            default: st_d = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st_q <= ST_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // Global enable: cleared entering the second cycle, set by return
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ie_q <= IE_RST;
      end else if (st_q == ST_ACK1 && st_d == ST_ACK2) begin
         ie_q <= 1'b0;
      end else if (return_from_irq_instruction_exec) begin
         ie_q <= 1'b1;
      end else if (wr_en && idx == IDX_CTL0) begin
         ie_q <= wval[IE_BIT];
      end
   end

   // Sequencer outputs registered from next state; push_pc spans two states, branch_en also on wake
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ack_busy_q   <= 1'b0;
         push_flags_q <= 1'b0;
         push_pc_q    <= 1'b0;
         branch_en_q  <= 1'b0;
         vec_q        <= VEC_RESET;
      end else begin
         ack_busy_q   <= st_d != ST_IDLE;
         push_flags_q <= st_d == ST_ACK2;
         push_pc_q    <= (st_d == ST_ACK2) || (st_d == ST_ACK3);
         branch_en_q  <= (st_d == ST_ACK3 && st_q != ST_ACK3) || wake;
         if (wake) begin
            vec_q <= VEC_RESET;
         end else if (st_q == ST_IDLE && st_d == ST_ACK1) begin
            vec_q <= enc_vec;
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         restore_q  <= 1'b0;
         wake_q     <= 1'b0;
         pend_any_q <= 1'b0;
      end else begin
         restore_q  <= return_from_irq_instruction_exec;
         wake_q     <= wake;
         pend_any_q <= |grp_pend;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   reset_values_a: assert property ($past(reset) |-> !ie_q && if_q == '0 && im_q == '1)
      else $error("control bits wrong after reset");

   no_sw_set_a: assert property (|(if_q & ~$past(if_q)) |-> |$past(src_set))
      else $error("request flag set without a source event");

   accept_cond_a: assert property ($past(st_q) == ST_IDLE && st_q == ST_ACK1
      |-> $past(ie_q) && $past(|grp_pend) && $past(cyc_en_q))
      else $error("acknowledge started without enabled pending request");

   vector_pick_a: assert property ($past(st_q) == ST_IDLE && st_q == ST_ACK1
      |-> vec_q == $past(enc_vec) && vec_q >= 14'h0002 && vec_q <= 14'h000E)
      else $error("vector does not match priority encoder");

   ie_clear_a: assert property (st_q == ST_ACK1 && cyc_en_q |=> !ie_q && st_q == ST_ACK2)
      else $error("enable not cleared in second acknowledge cycle");

   push_branch_a: assert property ($rose(push_flags_q)
      |-> (push_flags_q && push_pc_q) [*4]
      ##1 ($rose(branch_en_q) && !push_flags_q && push_pc_q))
      else $error("push and branch out of order");

   return_ie_a: assert property (return_from_irq_instruction_exec && st_q == ST_IDLE && !wr_en |=> ie_q && restore_q)
      else $error("return did not set enable");

   clear_drop_a: assert property (clr_now[SRC_PIN0] && !src_set[SRC_PIN0]
      |=> !if_q[SRC_PIN0] && !($past(st_q) == ST_IDLE && st_q == ST_ACK1 && vec_q == 14'h0002))
      else $error("cleared request still acknowledged");

   stop_wake_a: assert property (wake |=> branch_en_q && vec_q == VEC_RESET && wake_q)
      else $error("stop cancel did not branch to reset vector");

   pin_flag_a: assert property (eif.pin_event[0] |=> if_q[SRC_PIN0])
      else $error("falling edge on pin zero did not set flag");

   ack_seen_c: cover property (st_q == ST_ACK1 ##[1:20] branch_en_q);
   shared_vec_c: cover property (pend[SRC_TB] && pend[SRC_PIN2] && st_d == ST_ACK1);
   wake_seen_c: cover property (wake);
   clear_race_c: cover property (src_set[SRC_TA] && wr_hit[SRC_TA] && !wval[2]);

endmodule

// ==== verification/pviu_core_model.sv ====
module pviu_core_model import pviu_pkg::*; (
   // Clock and reset
   input  wire logic            core_clk,
   input  wire logic            reset,
   // Sequencer view of the unit
   input  wire logic            ack_busy,
   input  wire logic            push_flags,
   input  wire logic            push_pc,
   input  wire logic            branch_en,
   input  wire logic [PC_W-1:0] branch_vector,
   input  wire logic            restore_flags,
   input  wire logic            stop_wake,
   output logic                 return_from_irq_instruction_exec,
   // Observed counts
   output logic [7:0]           ack_cnt,
   output logic [7:0]           pf_cnt,
   output logic [7:0]           pp_cnt,
   output logic [7:0]           rest_cnt,
   output logic [7:0]           wake_cnt
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       busy_q;
   logic [7:0] ret_q;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         busy_q    <= 1'b0;
         ret_q     <= 8'h00;
         return_from_irq_instruction_exec <= 1'b0;
         ack_cnt   <= 8'h00;
         pf_cnt    <= 8'h00;
         pp_cnt    <= 8'h00;
         rest_cnt  <= 8'h00;
         wake_cnt  <= 8'h00;
      end else begin
         busy_q <= ack_busy;
         if (ack_busy && !busy_q) begin
            ack_cnt <= ack_cnt + 8'h01;
            pf_cnt  <= 8'h00;
            pp_cnt  <= 8'h00;
         end else begin
            pf_cnt <= pf_cnt + {7'h00, push_flags};
            pp_cnt <= pp_cnt + {7'h00, push_pc};
         end
         rest_cnt <= rest_cnt + {7'h00, restore_flags};
         wake_cnt <= wake_cnt + {7'h00, stop_wake};
         // Handler body runs a while, then the return instruction executes
         return_from_irq_instruction_exec <= (ret_q == 8'h01);
         if (branch_en && branch_vector != VEC_RESET) begin
            ret_q <= 8'h3C;
         end else if (ret_q != 8'h00) begin
            ret_q <= ret_q - 8'h01;
         end
      end
   end
endmodule

// ==== verification/test_prioritized_vector_interrupt_unit.sv ====
module test_prioritized_vector_interrupt_unit import pviu_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;

   logic            core_clk = 1'b0;
   logic            reset = 1'b1;
   logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]      paddr = 8'h00;
   logic [31:0]     pwdata = 32'h0, prdata, rd_q, seed;
   logic            ext_irq_pin_zero_n = 1'b1, ext_irq_pin_one_n = 1'b1;
   logic            ext_irq_pin_two_n = 1'b1, ext_irq_pin_three_n = 1'b1;
   logic            ext_irq_pin_four_n = 1'b1, stop_cancel_input = 1'b0;
   logic            timer_a_ovf = 1'b0, timer_b_ovf = 1'b0, timer_c_ovf = 1'b0;
   logic            timer_d_ovf = 1'b0, serial_req = 1'b0, adc_req = 1'b0;
   logic            stop_mode = 1'b0;
   logic            pready, pslverr, err_q, return_from_irq_instruction_exec, instr_cycle_en, ack_busy;
   logic            push_flags, push_pc, branch_en, restore_flags, stop_wake, irq_pending;
   logic [PC_W-1:0] branch_vector;
   logic [7:0]      ack_cnt, pf_cnt, pp_cnt, rest_cnt, wake_cnt;
   int              error_cnt = 0;
   int              checks_done = 0;
   logic [5:0]      ridx [6] = '{IDX_CTL0, IDX_CTL1, IDX_CTL2, IDX_CTL3, IDX_CTL22, IDX_CTL23};
   logic [3:0]      rexp [6] = '{4'h8, 4'hA, 4'hA, 4'hA, 4'hA, 4'hA};

   always #4 core_clk = ~core_clk;

   pviu_irq_unit i_dut (.*);
   pviu_core_model i_core (.*);

   task test_done;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task chk_reg(input logic [3:0] got, input logic [3:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t register got %h expected %h", $time, got, exp);
      end
   endtask

   task chk_out(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t output got %h expected %h", $time, got, exp);
      end
   endtask

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // One APB transfer; read data and error land in rd_q and err_q
   task apb(input logic [5:0] idx, input logic w, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'h0};
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         error_cnt++;
         test_done();
      end
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Single-bit write of one control bit
   task bop(input logic [5:0] idx, input int b, input logic v);
      apb(idx, 1'b1, {23'h0, 1'b1, 2'h0, b[1:0], 3'h0, v});
   endtask

   task wait_br;
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (branch_en !== 1'b1 && n < 300);
      if (branch_en !== 1'b1) begin
         error_cnt++;
         test_done();
      end
   endtask

   task fire(input logic [10:0] s);
      @(posedge core_clk);
      timer_a_ovf <= s[SRC_TA];
      timer_b_ovf <= s[SRC_TB];
      timer_c_ovf <= s[SRC_TC];
      timer_d_ovf <= s[SRC_TD];
      adc_req <= s[SRC_AD];
      serial_req <= s[SRC_SER];
      {ext_irq_pin_four_n, ext_irq_pin_three_n, ext_irq_pin_two_n} <=
         ~{s[SRC_PIN4], s[SRC_PIN3], s[SRC_PIN2]};
      {ext_irq_pin_one_n, ext_irq_pin_zero_n} <= ~{s[SRC_PIN1], s[SRC_PIN0]};
      @(posedge core_clk);
      {timer_a_ovf, timer_b_ovf, timer_c_ovf, timer_d_ovf, adc_req, serial_req} <= 6'h00;
      repeat (8) @(posedge core_clk);
      {ext_irq_pin_four_n, ext_irq_pin_three_n, ext_irq_pin_two_n} <= 3'h7;
      {ext_irq_pin_one_n, ext_irq_pin_zero_n} <= 2'h3;
      repeat (20) @(posedge core_clk);
   endtask

   // Unmask the chosen sources, raise them, enable, then act as the handler
   task irq_case(input logic [10:0] s);
      int g;
      int n;
      logic [7:0] a0;
      logic [7:0] r0;
      g = NUM_GRP;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (s[i]) begin
            bop(SRC_REG[i], 2 * SRC_PAIR[i] + 1, 1'b0);
            if (SRC_GRP[i] < g) g = SRC_GRP[i];
         end
      end
      a0 = ack_cnt;
      fire(s);
      chk_out({15'h0, irq_pending}, 16'h1);
      chk_out({8'h0, ack_cnt}, {8'h0, a0});
      bop(IDX_CTL0, IE_BIT, 1'b1);
      wait_br();
      chk_out({2'h0, branch_vector}, 16'(VEC_STEP * (g + 1)));
      repeat (5) @(posedge core_clk);
      chk_out({8'h0, pf_cnt}, 16'(INSTR_DIV_CYCLES));
      chk_out({8'h0, pp_cnt}, 16'(2 * INSTR_DIV_CYCLES));
      apb(IDX_CTL0, 1'b0, 32'h0);
      chk_reg({3'h0, rd_q[IE_BIT]}, 4'h0);
      for (int i = 0; i < NUM_SRC; i++) begin
         if (s[i]) begin
            apb(SRC_REG[i], 1'b0, 32'h0);
            chk_reg({3'h0, rd_q[2 * SRC_PAIR[i]]}, 4'h1);
            bop(SRC_REG[i], 2 * SRC_PAIR[i], 1'b0);
            bop(SRC_REG[i], 2 * SRC_PAIR[i] + 1, 1'b1);
         end
      end
      chk_out({15'h0, irq_pending}, 16'h0);
      r0 = rest_cnt;
      n = 0;
      while (rest_cnt === r0 && n < 300) begin
         @(posedge core_clk);
         n++;
      end
      chk_out({8'h0, rest_cnt}, {8'h0, r0 + 8'h01});
      if (n >= 300) test_done();
      apb(IDX_CTL0, 1'b0, 32'h0);
      chk_reg({3'h0, rd_q[IE_BIT]}, 4'h1);
      repeat (20) @(posedge core_clk);
      chk_out({8'h0, ack_cnt}, {8'h0, a0 + 8'h01});
      bop(IDX_CTL0, IE_BIT, 1'b0);
   endtask

   initial begin
      logic [7:0] w0;
      seed = 32'd88705;
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      for (int k = 0; k < 6; k++) begin
         apb(ridx[k], 1'b0, 32'h0);
         chk_reg(rd_q[3:0], rexp[k]);
      end
      apb(6'h10, 1'b0, 32'h0);
      chk_out({15'h0, err_q}, 16'h1);
      apb(IDX_CTL1, 1'b1, 32'h0000000F);
      apb(IDX_CTL1, 1'b0, 32'h0);
      chk_reg(rd_q[3:0], 4'hA);
      fire(11'h004);
      apb(IDX_CTL1, 1'b0, 32'h0);
      chk_reg(rd_q[3:0], 4'hE);
      chk_out({15'h0, irq_pending}, 16'h0);
      bop(IDX_CTL1, 2, 1'b0);
      apb(IDX_CTL1, 1'b0, 32'h0);
      chk_reg(rd_q[3:0], 4'hA);
      // Pin 2 rising, pin 3 both edges, pin 4 falling
      apb(IDX_EDGE_SELECT_REG_ONE, 1'b1, 32'h0000000E);
      apb(IDX_EDGE_SELECT_REG_TWO, 1'b1, 32'h00000001);
      $display("reset and register tests done");
      for (int i = 0; i < NUM_SRC; i++) irq_case(11'h001 << i);
      $display("single source tests done");
      for (int k = 0; k < 12; k++) begin
         irq_case((11'h001 << (rnd() % 11)) | (11'h001 << (rnd() % 11)));
      end
      $display("random pair tests done");
      w0 = wake_cnt;
      stop_cancel_input <= 1'b1;
      repeat (10) @(posedge core_clk);
      stop_cancel_input <= 1'b0;
      repeat (10) @(posedge core_clk);
      chk_out({8'h0, wake_cnt}, {8'h0, w0});
      stop_mode <= 1'b1;
      stop_cancel_input <= 1'b1;
      wait_br();
      chk_out({2'h0, branch_vector}, {2'h0, VEC_RESET});
      repeat (2) @(posedge core_clk);
      chk_out({8'h0, wake_cnt}, {8'h0, w0 + 8'h01});
      stop_cancel_input <= 1'b0;
      stop_mode <= 1'b0;
      $display("stop cancel tests done");
      test_done();
   end
endmodule
